// >>> hw/status_indicator_consts.svh
/*
  timing constants for the status indicator driver.
  assumes a 250 MHz core clock; counts derive from the ms figures.
*/
`ifndef STATUS_INDICATOR_CONSTS_SVH
`define STATUS_INDICATOR_CONSTS_SVH

// ==========================================
// clock and cadence times
`define CORE_CLK_HZ 250000000
`define CYCLES_PER_MS (`CORE_CLK_HZ / 1000)
`define SEARCH_HIGH_MS 200
`define SEARCH_LOW_MS 1800
`define IDLE_HIGH_MS 1800
`define IDLE_LOW_MS 200
`define DATA_HIGH_MS 125
`define DATA_LOW_MS 125

// ==========================================
// tick divider: one enable pulse per millisecond
`define TICK_CYCLES `CYCLES_PER_MS

`endif

// >>> hw/status_indicator_pkg.sv
/*
  types shared by the status indicator driver.
  assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package status_indicator_pkg;

  // network conditions reported by the module's controller
  typedef struct packed {
    logic searching;
    logic idle;
    logic data_transfer;
    logic voice_call;
  } net_state_type;

  typedef enum logic [2:0] {
    mode_off,
    mode_search,
    mode_idle,
    mode_data,
    mode_voice
  } blink_mode_type;

  // open-drain pin as output and enable
  typedef struct packed {
    logic out;
    logic oe;
  } od_pin_type;

endpackage

`default_nettype wire

// >>> hw/ms_tick_divider.sv
/*
  divides the core clock down to a one-cycle enable pulse.
  assumes one clock domain; restart aligns the pulse to a new phase.
*/
`default_nettype none

module ms_tick_divider #(
  parameter int unsigned DIVIDE = 250000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // control
  input wire logic restart,
  // enable pulse
  output logic tick
);

  localparam int unsigned W = $clog2(DIVIDE);

  logic [W-1:0] count;

  // ==========================================
  // counter
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      tick <= 1'b0;
    end else if (restart) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count == W'(DIVIDE - 1)) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> hw/status_indicator_driver.sv
/*
  network activity blinker and open-drain run-status output.
  assumes state inputs and power-up flag come from core_clk logic;
  the board supplies the pull-up on the run-status pin.
*/
// Behaviour
// - searching: 200 ms high, 1800 ms low
// - idle: 1800 ms high, 200 ms low
// - data transfer: 125 ms high, 125 ms low
// - voice call: output steadily high
// - after normal power-up, pull run-status low
// - otherwise release run-status; never drive high
`include "status_indicator_consts.svh"
`default_nettype none

module status_indicator_driver
  import status_indicator_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // module condition
  input wire status_indicator_pkg::net_state_type net_state,
  input wire logic powered_up,
  // pins
  output logic network_activity_indicator,
  output status_indicator_pkg::od_pin_type run_status
);
  import status_indicator_pkg::*;

  blink_mode_type mode;
  blink_mode_type next_mode;
  logic [10:0] ms_count;
  logic [10:0] high_ms;
  logic [10:0] low_ms;
  logic phase_high;
  logic tick;
  logic restart;

  // ==========================================
  // mode selection
  always_comb begin
    if (net_state.voice_call) begin
      next_mode = mode_voice;
    end else if (net_state.data_transfer) begin
      next_mode = mode_data;
    end else if (net_state.idle) begin
      next_mode = mode_idle;
    end else if (net_state.searching) begin
      next_mode = mode_search;
    end else begin
      next_mode = mode_off;
    end
  end

  assign restart = (next_mode != mode);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= mode_off;
    end else begin
      mode <= next_mode;
    end
  end

  // ==========================================
  // phase lengths per mode
  always_comb begin
    case (mode)
      mode_search: begin
        high_ms = 11'(`SEARCH_HIGH_MS);
        low_ms = 11'(`SEARCH_LOW_MS);
      end
      mode_idle: begin
        high_ms = 11'(`IDLE_HIGH_MS);
        low_ms = 11'(`IDLE_LOW_MS);
      end
      mode_data: begin
        high_ms = 11'(`DATA_HIGH_MS);
        low_ms = 11'(`DATA_LOW_MS);
      end
      default: begin
        high_ms = 11'h001;
        low_ms = 11'h001;
      end
    endcase
  end

  ms_tick_divider #(
    .DIVIDE(TICK_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .restart(restart),
    .tick(tick)
  );

  // ==========================================
  // cadence: a state change starts again with a high phase
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ms_count <= 11'h000;
      phase_high <= 1'b1;
    end else if (restart) begin
      ms_count <= 11'h000;
      phase_high <= 1'b1;
    end else if (tick) begin
      if (ms_count == (phase_high ? high_ms : low_ms) - 11'h001) begin
        ms_count <= 11'h000;
        phase_high <= !phase_high;
      end else begin
        ms_count <= ms_count + 11'h001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      network_activity_indicator <= 1'b0;
    end else begin
      case (next_mode)
        mode_voice: network_activity_indicator <= 1'b1;
        mode_off: network_activity_indicator <= 1'b0;
        default: begin
          // on restart the first phase is high already
          network_activity_indicator <= restart ? 1'b1 : phase_high;
        end
      endcase
    end
  end

  // ==========================================
  // open-drain run status; out is tied low so it can never drive high
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_status <= '{out: 1'b0, oe: 1'b0};
    end else begin
      run_status <= '{out: 1'b0, oe: powered_up};
    end
  end

  // ==========================================
  // checks
  // the release edge still runs the flops in reset, so checks start one edge later
  logic checks_on;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      checks_on <= 1'b0;
    end else begin
      checks_on <= 1'b1;
    end
  end

  voice_steady_high_a: assert property (@(posedge core_clk) disable iff (!rst_b || !checks_on)
    net_state.voice_call |=> network_activity_indicator)
    else $error("indicator not high during voice call");

  od_never_high_a: assert property (@(posedge core_clk) disable iff (!rst_b || !checks_on)
    run_status.out == 1'b0)
    else $error("run status driven high");

  od_follows_up_a: assert property (@(posedge core_clk) disable iff (!rst_b || !checks_on)
    powered_up |=> run_status.oe)
    else $error("run status not pulled low after power-up");

  od_release_a: assert property (@(posedge core_clk) disable iff (!rst_b || !checks_on)
    !powered_up |=> !run_status.oe)
    else $error("run status not released");

  restart_high_a: assert property (@(posedge core_clk) disable iff (!rst_b || !checks_on)
    (restart && next_mode != mode_off) |=> network_activity_indicator)
    else $error("cadence did not restart high");

  data_over_idle_a: assert property (@(posedge core_clk) disable iff (!rst_b || !checks_on)
    (net_state.data_transfer && !net_state.voice_call) |=> mode == mode_data)
    else $error("data transfer priority lost");

  idle_over_search_a: assert property (@(posedge core_clk) disable iff (!rst_b || !checks_on)
    (net_state.idle && !net_state.data_transfer && !net_state.voice_call)
    |=> mode == mode_idle)
    else $error("idle priority lost");

  no_state_low_a: assert property (@(posedge core_clk) disable iff (!rst_b || !checks_on)
    (next_mode == mode_off) |=> !network_activity_indicator)
    else $error("indicator lit with no state");

  cadence_reset_a: assert property (@(posedge core_clk) disable iff (!rst_b || !checks_on)
    restart |=> (ms_count == 11'h000 && phase_high))
    else $error("cadence not restarted");

  phase_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b || !checks_on)
    (!tick && !restart) |=> $stable(phase_high))
    else $error("phase moved between ticks");

  search_len_a: assert property (@(posedge core_clk) disable iff (!rst_b || !checks_on)
    (mode == mode_search && tick && phase_high && ms_count == 11'd199 && !restart)
    |=> !phase_high)
    else $error("search high phase length wrong");

  search_no_early_a: assert property (@(posedge core_clk) disable iff (!rst_b || !checks_on)
    (mode == mode_search && tick && phase_high && ms_count < 11'd199 && !restart)
    |=> phase_high)
    else $error("search high phase ended early");

  search_low_len_a: assert property (@(posedge core_clk) disable iff (!rst_b || !checks_on)
    (mode == mode_search && tick && !phase_high && ms_count == 11'd1799 && !restart)
    |=> phase_high)
    else $error("search low phase length wrong");

  idle_len_a: assert property (@(posedge core_clk) disable iff (!rst_b || !checks_on)
    (mode == mode_idle && tick && phase_high && ms_count == 11'd1799 && !restart)
    |=> !phase_high)
    else $error("idle high phase length wrong");

  idle_low_len_a: assert property (@(posedge core_clk) disable iff (!rst_b || !checks_on)
    (mode == mode_idle && tick && !phase_high && ms_count == 11'd199 && !restart)
    |=> phase_high)
    else $error("idle low phase length wrong");

  data_high_len_a: assert property (@(posedge core_clk) disable iff (!rst_b || !checks_on)
    (mode == mode_data && tick && phase_high && ms_count == 11'd124 && !restart)
    |=> !phase_high)
    else $error("data high phase length wrong");

  data_len_a: assert property (@(posedge core_clk) disable iff (!rst_b || !checks_on)
    (mode == mode_data && tick && !phase_high && ms_count == 11'd124 && !restart)
    |=> phase_high)
    else $error("data low phase length wrong");

endmodule

`default_nettype wire

// >>> tb/status_pin_model.sv
/*
  far side of the run-status pin: the board pull-up and the host input.
  assumes the pin is split into out and oe, oe high while pulled low.
*/
`default_nettype none

module status_pin_model
  import status_indicator_pkg::*;
(
  // pin from the driver
  input wire status_indicator_pkg::od_pin_type run_status,
  // level seen by the host
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // released pin floats up to the pull-up, never left unknown
  assign pin_level = run_status.oe ? run_status.out : 1'b1;
endmodule

`default_nettype wire

// >>> tb/test_status_indicator_driver.sv
/*
  self-checking bench for the status indicator driver.
  assumes TICK_CYCLES shortened to 4; phases judged within a few cycles.
*/
`default_nettype none

module test_status_indicator_driver;
  timeunit 1ns;
  timeprecision 1ps;
  import status_indicator_pkg::*;
  localparam int unsigned TICK = 4;
  logic core_clk, rst_b, powered_up, led, pin;
  net_state_type net_state;
  od_pin_type run_status;
  int fails, n_tests;
  status_indicator_driver #(.TICK_CYCLES(TICK)) dut_u (.core_clk(core_clk), .rst_b(rst_b),
    .net_state(net_state), .powered_up(powered_up),
    .network_activity_indicator(led), .run_status(run_status));
  status_pin_model model_u (.run_status(run_status), .pin_level(pin));
  // ==========================================
  // helpers
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, exp, tol);
    logic ok;
    ok = (seen + tol >= exp) && (seen <= exp + tol);
    n_tests++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // counts cycles the led stays at lvl, up to cap
  task automatic run_len(input logic lvl, input logic [31:0] cap, output logic [31:0] n);
    n = 0;
    while (led === lvl && n < cap) begin
      n++;
      @(negedge core_clk);
    end
  endtask
  task automatic apply(input net_state_type st);
    @(posedge core_clk) net_state <= st;
    repeat (3) @(negedge core_clk);
  endtask
  // latency eats up to 3 cycles of the first high phase
  task automatic cadence(input net_state_type st, input logic [31:0] h, l);
    logic [31:0] n;
    apply(st);
    check("restart high", led, 1, 0);
    run_len(1'b1, 20000, n);
    check("high phase", n, h * TICK, 4);
    run_len(1'b0, 20000, n);
    check("low phase", n, l * TICK, 4);
  endtask
  // ==========================================
  // scenarios
  task automatic test_run_status;
    check("released oe", run_status.oe, 0, 0);
    check("released pin", pin, 1, 0);
    @(posedge core_clk) powered_up <= 1'b1;
    repeat (3) @(negedge core_clk);
    check("pulled pin", pin, 0, 0);
    check("never high", run_status.out, 0, 0);
    @(posedge core_clk) powered_up <= 1'b0;
    repeat (3) @(negedge core_clk);
    check("released again", pin, 1, 0);
    $display("test run status done");
  endtask
  task automatic test_search;
    cadence(4'b1000, 200, 1800);
    $display("test search done");
  endtask
  task automatic test_idle;
    cadence(4'b1100, 1800, 200);
    $display("test idle done");
  endtask
  task automatic test_voice;
    logic [31:0] n;
    apply(4'b1111);
    run_len(1'b1, 1000, n);
    check("voice steady", n, 1000, 0);
    apply(4'b0000);
    check("no state", led, 0, 0);
    $display("test voice done");
  endtask
  task automatic test_data;
    cadence(4'b1110, 125, 125);
    $display("test data done");
  endtask
  // reset in mid-blink with inputs active; outputs must come back one edge after release
  task automatic test_mid_reset;
    @(posedge core_clk) powered_up <= 1'b1;
    repeat (3) @(negedge core_clk);
    check("data before reset", led, 1, 0);
    check("up before reset", pin, 0, 0);
    @(posedge core_clk) rst_b <= 1'b0;
    @(negedge core_clk);
    check("pin in reset", pin, 1, 0);
    @(posedge core_clk) rst_b <= 1'b1;
    repeat (2) @(negedge core_clk);
    check("led after reset", led, 1, 0);
    check("pin after reset", pin, 0, 0);
    $display("test mid reset done");
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    rst_b = 1'b0;
    powered_up = 1'b0;
    net_state = '0;
    fails = 0;
    n_tests = 0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    test_run_status;
    test_search;
    test_idle;
    test_voice;
    test_data;
    test_mid_reset;
    finish_test;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    fails++;
    finish_test;
  end
endmodule

`default_nettype wire
